/* kms_pkg.sv */
// Constants, field positions, types and reset values of the key matrix scanner.
// Assumes a 100 MHz core clock and a separate link clock for the host register port.
package kms_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  localparam int NUM_COLS = 8;
  localparam int NUM_ROWS = 8;
  localparam int NUM_KEYS = 64;
  localparam int FIFO_DEPTH = 16;
  localparam int FIRST_GPO_COL = 2;

  localparam logic [7:0] ADDR_EVQ = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h01;
  localparam logic [7:0] ADDR_DBC = 8'h02;
  localparam logic [7:0] ADDR_IRQ = 8'h03;
  localparam logic [7:0] ADDR_PORT = 8'h04;
  localparam logic [7:0] ADDR_REP = 8'h05;
  localparam logic [7:0] ADDR_SLP = 8'h06;

  localparam logic [7:0] RST_CFG = 8'h0A;
  localparam logic [7:0] RST_DBC = 8'hFF;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [7:0] RST_PORT = 8'hFE;
  localparam logic [7:0] RST_REP = 8'h00;
  localparam logic [7:0] RST_SLP = 8'h07;
  localparam logic [7:0] RST_ROWS = 8'hFF;

  localparam int CFG_SLEEP_BIT = 7;
  localparam logic [7:0] CFG_RSVD_MASK = 8'h40;
  localparam int CFG_INTCLR_BIT = 5;
  localparam int CFG_RELEASE_BIT = 3;
  localparam int CFG_AUTOWAKE_BIT = 1;
  localparam int CFG_TIMEOUT_BIT = 0;
  localparam int DBC_TIME_MSB = 4;
  localparam int DBC_GPO_LSB = 5;
  localparam int DBC_GPO_MSB = 7;
  localparam int IRQ_THR_MSB = 4;
  localparam int IRQ_PER_LSB = 5;
  localparam int IRQ_PER_MSB = 7;
  localparam int PORT_INT_GPO_BIT = 0;
  localparam int PORT_INT_LVL_BIT = 1;
  localparam int REP_DELAY_MSB = 3;
  localparam int REP_RATE_LSB = 4;
  localparam int REP_RATE_MSB = 6;
  localparam int REP_EN_BIT = 7;
  localparam int SLP_CODE_MSB = 2;

  localparam logic [5:0] DBC_BASE_MS = 6'h09;
  localparam logic [9:0] REP_DELAY_UNIT_MS = 10'h020;
  localparam logic [9:0] REP_RATE_UNIT_MS = 10'h010;
  localparam logic [5:0] IRQ_UNIT_MS = 6'h08;
  localparam logic [10:0] SLEEP_UNIT_MS = 11'h100;

  localparam logic [7:0] CODE_EMPTY = 8'h3F;
  localparam logic [7:0] CODE_OVERFLOW = 8'h7F;
  localparam logic [5:0] KEY_REPEAT = 6'h3E;
  localparam logic [5:0] KEY_SPECIAL_LO = 6'h3E;

  typedef enum logic [1:0] {
    KIND_PRESS = 2'h0,
    KIND_RELEASE = 2'h1,
    KIND_REPEAT = 2'h2
  } kms_kind_e;

  typedef struct packed {
    kms_kind_e kind;
    logic [5:0] key;
  } kms_entry_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DEBOUNCE = 5'b00010,
    ST_SCAN = 5'b00100,
    ST_WALK = 5'b01000,
    ST_RECOVER = 5'b10000
  } kms_state_e;
endpackage

/* kms_sync.sv */
// Two flip-flop synchroniser for levels and toggles entering a clock domain.
// Assumes the reset input is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module kms_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // kms_sync
`default_nettype wire

/* kms_top.sv */
// Key matrix scanner with event queue, sleep control, interrupt and open-drain outputs.
// Assumes pull-ups on the row lines and a host register port on its own link clock.
`timescale 1ns/1ps
`default_nettype none
module kms_top import kms_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_CYCLES,
  parameter int SETTLE_WAIT = SETTLE_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic link_req,
  input wire logic link_we,
  input wire logic [7:0] link_addr,
  input wire logic [7:0] link_wdata,
  output logic link_busy,
  output logic link_ack,
  output logic [7:0] link_rdata,
  input wire logic [7:0] row_sense_in,
  output logic [7:0] column_drive_out,
  output logic [7:0] column_drive_oe_n,
  output logic irq_pin_out,
  output logic irq_pin_oe_n,
  output logic bus_timeout_en
);
  localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);
  localparam logic [4:0] FULL_COUNT = 5'(FIFO_DEPTH);
  localparam logic [2:0] LAST_COL = 3'(NUM_COLS - 1);
  localparam logic [5:0] LAST_KEY = 6'(NUM_KEYS - 1);

  // Link domain: capture one request, hold it stable, wait for the core's toggle back
  logic lk_rst, lk_busy_q, lk_ack_q, lk_tgl_q, lk_we_q, lk_ack_seen_q, lk_ack_sync;
  logic [7:0] lk_addr_q, lk_wdata_q, lk_rdata_q;
  logic core_ack_tgl_q, req_sync, req_seen_q;
  logic [7:0] core_rdata_q;

  kms_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_lk_rst (
    .clk(link_clk), .rst(1'b0), .d(srst), .q(lk_rst));
  kms_sync #(.WIDTH(1)) u_ack_sync (
    .clk(link_clk), .rst(lk_rst), .d(core_ack_tgl_q), .q(lk_ack_sync));

  wire lk_take = link_req & ~lk_busy_q;
  wire lk_done = lk_ack_sync ^ lk_ack_seen_q;

  always_ff @(posedge link_clk) begin
    if (lk_rst) begin
      lk_busy_q <= 1'b0;
      lk_ack_q <= 1'b0;
      lk_tgl_q <= 1'b0;
      lk_we_q <= 1'b0;
      lk_ack_seen_q <= 1'b0;
      lk_addr_q <= 8'h00;
      lk_wdata_q <= 8'h00;
      lk_rdata_q <= 8'h00;
    end else begin
      lk_ack_q <= lk_done;
      lk_ack_seen_q <= lk_ack_sync;
      if (lk_take) begin
        lk_tgl_q <= ~lk_tgl_q;
        lk_busy_q <= 1'b1;
        lk_addr_q <= link_addr;
        lk_we_q <= link_we;
        lk_wdata_q <= link_wdata;
      end else if (lk_done) begin
        lk_busy_q <= 1'b0;
      end
      // Core read data has been held stable since the edge that sent its toggle
      if (lk_done) lk_rdata_q <= core_rdata_q;
    end
  end

  assign link_busy = lk_busy_q;
  assign link_ack = lk_ack_q;
  assign link_rdata = lk_rdata_q;

  // Core domain command decode; request fields are stable while the link is busy
  kms_sync #(.WIDTH(1)) u_req_sync (
    .clk(core_clk), .rst(srst), .d(lk_tgl_q), .q(req_sync));

  wire host_cmd = req_sync ^ req_seen_q;
  wire host_wr = host_cmd & lk_we_q;
  wire host_rd = host_cmd & ~lk_we_q;
  wire wr_cfg = host_wr && (lk_addr_q == ADDR_CFG);
  wire wr_dbc = host_wr && (lk_addr_q == ADDR_DBC);
  wire wr_irq = host_wr && (lk_addr_q == ADDR_IRQ);
  wire wr_port = host_wr && (lk_addr_q == ADDR_PORT);
  wire wr_rep = host_wr && (lk_addr_q == ADDR_REP);
  wire wr_slp = host_wr && (lk_addr_q == ADDR_SLP);
  wire evq_read = host_rd && (lk_addr_q == ADDR_EVQ);

  logic [7:0] cfg_q, dbc_q, irqset_q, port_q, rep_q, slp_q;
  logic [7:0] row_s, row_last_q, evq_value, rd_value;
  logic [NUM_COLS-1:0] gpo_mask, col_oe_n_d, col_oe_n_q;
  logic [NUM_KEYS-1:0] raw_q, stable_q;
  kms_state_e state_q, state_d;
  logic [TICK_W-1:0] tick_cnt_q;
  logic [5:0] dbc_ms_q, irq_ms_q;
  logic [7:0] settle_q;
  logic [2:0] col_idx_q;
  logic [5:0] key_idx_q, rep_key_q;
  logic [9:0] rep_ms_q;
  logic [10:0] idle_ms_q;
  logic rep_valid_q, rep_first_q, irq_flag_q, ovf_q, irq_oe_n_q;
  kms_entry_s fifo_mem [FIFO_DEPTH];
  logic [3:0] wr_ptr_q, rd_ptr_q;
  logic [4:0] count_q;

  kms_sync #(.WIDTH(NUM_ROWS), .RST_VAL(RST_ROWS)) u_row_sync (
    .clk(core_clk), .rst(srst), .d(row_sense_in), .q(row_s));

  wire awake = cfg_q[CFG_SLEEP_BIT];
  wire tick = tick_cnt_q == TICK_W'(MS_TICK_CYCLES - 1);
  wire settle_done = settle_q == 8'(SETTLE_WAIT + SYNC_STAGES);
  wire [5:0] dbc_target = 6'(dbc_q[DBC_TIME_MSB:0]) + DBC_BASE_MS;
  wire [3:0] gpo_first = 4'(dbc_q[DBC_GPO_MSB:DBC_GPO_LSB]) + 4'(FIRST_GPO_COL);

  // Column outputs: all key columns low at rest, one at a time only during a scan
  genvar c;
  for (c = 0; c < NUM_COLS; c++) begin : g_col
    assign gpo_mask[c] = (c >= FIRST_GPO_COL) && (4'(c) >= gpo_first);
    assign col_oe_n_d[c] = gpo_mask[c] ? port_q[c] :
                           ((state_q == ST_SCAN) && (col_idx_q != 3'(c)));
  end

  // Walk compares the fresh snapshot with the debounced state, one key per cycle
  wire [2:0] walk_col = key_idx_q[5:3];
  wire walk_raw = raw_q[key_idx_q] & ~gpo_mask[walk_col];
  wire walk_diff = (state_q == ST_WALK) && (walk_raw != stable_q[key_idx_q]);
  wire walk_press = walk_diff & walk_raw;
  wire walk_rel = walk_diff & ~walk_raw & cfg_q[CFG_RELEASE_BIT];

  wire rep_on = rep_q[REP_EN_BIT] && rep_valid_q && stable_q[rep_key_q] &&
                (state_q == ST_IDLE) && awake;
  wire [9:0] rep_delay_ms = 10'(5'(rep_q[REP_DELAY_MSB:0]) + 5'h01) * REP_DELAY_UNIT_MS;
  wire [9:0] rep_rate_ms = 10'(4'(rep_q[REP_RATE_MSB:REP_RATE_LSB]) + 4'h1) * REP_RATE_UNIT_MS;
  wire [9:0] rep_target = rep_first_q ? rep_delay_ms : rep_rate_ms;
  wire rep_fire = rep_on && tick && (rep_ms_q + 10'h001 >= rep_target);

  wire push_v = walk_press | walk_rel | rep_fire;
  kms_entry_s push_data;
  assign push_data.kind = rep_fire ? KIND_REPEAT : (walk_raw ? KIND_PRESS : KIND_RELEASE);
  assign push_data.key = rep_fire ? KEY_REPEAT : key_idx_q;
  wire full = count_q == FULL_COUNT;
  wire push_ok = push_v && !full;
  wire pop = evq_read && !ovf_q && (count_q != 5'h00);

  // Queue head formatted with status flags in the same byte
  kms_entry_s head;
  assign head = fifo_mem[rd_ptr_q];
  wire more = count_q > 5'h01;
  wire head_rel = head.kind == KIND_RELEASE;
  always_comb begin
    if (ovf_q) begin
      evq_value = CODE_OVERFLOW;
    end else if (count_q == 5'h00) begin
      evq_value = CODE_EMPTY;
    end else if (head.kind == KIND_REPEAT) begin
      evq_value = {1'b0, more, KEY_REPEAT};
    end else if (head.key >= KEY_SPECIAL_LO) begin
      evq_value = {1'b1, head_rel, head.key};
    end else begin
      evq_value = {more, head_rel, head.key};
    end
  end

  always_comb begin
    rd_value = 8'h00;
    if (lk_addr_q == ADDR_EVQ) begin
      rd_value = evq_value;
    end else if (lk_addr_q == ADDR_CFG) begin
      rd_value = cfg_q;
    end else if (lk_addr_q == ADDR_DBC) begin
      rd_value = dbc_q;
    end else if (lk_addr_q == ADDR_IRQ) begin
      rd_value = irqset_q;
    end else if (lk_addr_q == ADDR_PORT) begin
      rd_value = port_q;
    end else if (lk_addr_q == ADDR_REP) begin
      rd_value = rep_q;
    end else if (lk_addr_q == ADDR_SLP) begin
      rd_value = slp_q;
    end
  end

  // Sleep control; a host write wins over the automatic changes in the same cycle
  wire [10:0] sleep_target = 11'(slp_q[SLP_CODE_MSB:0]) * SLEEP_UNIT_MS;
  wire auto_sleep = awake && (slp_q[SLP_CODE_MSB:0] != 3'h0) && (state_q == ST_IDLE) &&
                    (stable_q == '0) && (idle_ms_q >= sleep_target);
  wire auto_wake = !awake && cfg_q[CFG_AUTOWAKE_BIT] && (row_s != RST_ROWS);

  // Interrupt: level mode when the period field is zero, time mode otherwise
  wire [2:0] irq_period = irqset_q[IRQ_PER_MSB:IRQ_PER_LSB];
  wire [4:0] irq_thr = irqset_q[IRQ_THR_MSB:0];
  wire [5:0] thr_eff = (irq_thr == 5'h00) ? 6'h01 : 6'(irq_thr);
  wire [5:0] irq_target = 6'(irq_period) * IRQ_UNIT_MS;
  wire level_set = (irq_period == 3'h0) && push_ok && (6'(count_q) + 6'h01 >= thr_eff);
  wire time_set = (irq_period != 3'h0) && (count_q != 5'h00) && !irq_flag_q &&
                  (irq_ms_q >= irq_target);
  wire irq_set = level_set | time_set;
  wire irq_clr = cfg_q[CFG_INTCLR_BIT] ? evq_read : (count_q == 5'h00);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (awake && (row_s != row_last_q)) state_d = ST_DEBOUNCE;
      ST_DEBOUNCE: if (tick && (dbc_ms_q + 6'h01 >= dbc_target)) state_d = ST_SCAN;
      ST_SCAN: if (settle_done && (col_idx_q == LAST_COL)) state_d = ST_WALK;
      ST_WALK: if (key_idx_q == LAST_KEY) state_d = ST_RECOVER;
      ST_RECOVER: if (settle_done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_seen_q <= 1'b0;
      core_ack_tgl_q <= 1'b0;
      core_rdata_q <= 8'h00;
    end else begin
      req_seen_q <= req_sync;
      if (host_cmd) begin
        core_rdata_q <= rd_value;
        core_ack_tgl_q <= ~core_ack_tgl_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_q <= RST_CFG;
      dbc_q <= RST_DBC;
      irqset_q <= RST_IRQ;
      port_q <= RST_PORT;
      rep_q <= RST_REP;
      slp_q <= RST_SLP;
    end else begin
      if (wr_cfg) cfg_q <= lk_wdata_q & ~CFG_RSVD_MASK;
      else if (auto_sleep) cfg_q[CFG_SLEEP_BIT] <= 1'b0;
      else if (auto_wake) cfg_q[CFG_SLEEP_BIT] <= 1'b1;
      if (wr_dbc) dbc_q <= lk_wdata_q;
      if (wr_irq) irqset_q <= lk_wdata_q;
      if (wr_port) port_q <= lk_wdata_q;
      if (wr_rep) rep_q <= lk_wdata_q;
      if (wr_slp) slp_q <= lk_wdata_q;
    end
  end

  // Queue memory has no reset; only entries below count_q are ever read
  always_ff @(posedge core_clk) begin
    if (push_ok) fifo_mem[wr_ptr_q] <= push_data;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
      ovf_q <= 1'b0;
    end else begin
      if (push_ok) wr_ptr_q <= wr_ptr_q + 4'h1;
      if (pop) rd_ptr_q <= rd_ptr_q + 4'h1;
      count_q <= count_q + 5'(push_ok) - 5'(pop);
      if (push_v && full) ovf_q <= 1'b1;
      else if (evq_read) ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      tick_cnt_q <= '0;
      dbc_ms_q <= 6'h00;
      settle_q <= 8'h00;
      col_idx_q <= 3'h0;
      key_idx_q <= 6'h00;
      row_last_q <= RST_ROWS;
      raw_q <= '0;
      stable_q <= '0;
    end else begin
      state_q <= state_d;
      tick_cnt_q <= tick ? '0 : tick_cnt_q + TICK_W'(1);
      if (state_q != ST_DEBOUNCE) dbc_ms_q <= 6'h00;
      else if (tick) dbc_ms_q <= dbc_ms_q + 6'h01;
      if (state_q == ST_DEBOUNCE && state_d == ST_SCAN) row_last_q <= row_s;
      if ((state_q == ST_SCAN || state_q == ST_RECOVER) && !settle_done) begin
        settle_q <= settle_q + 8'h01;
      end else begin
        settle_q <= 8'h00;
      end
      if (state_q == ST_SCAN && settle_done) begin
        raw_q[col_idx_q * NUM_ROWS +: NUM_ROWS] <= ~row_s;
        col_idx_q <= col_idx_q + 3'h1;
      end
      if (state_q == ST_WALK) begin
        key_idx_q <= key_idx_q + 6'h01;
        if (walk_diff) stable_q[key_idx_q] <= walk_raw;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rep_valid_q <= 1'b0;
      rep_first_q <= 1'b1;
      rep_key_q <= 6'h00;
      rep_ms_q <= 10'h000;
      idle_ms_q <= 11'h000;
      irq_ms_q <= 6'h00;
      irq_flag_q <= 1'b0;
    end else begin
      if (walk_press) begin
        rep_valid_q <= 1'b1;
        rep_key_q <= key_idx_q;
        rep_first_q <= 1'b1;
        rep_ms_q <= 10'h000;
      end else if (walk_diff && key_idx_q == rep_key_q) begin
        rep_valid_q <= 1'b0;
      end else if (rep_fire) begin
        rep_first_q <= 1'b0;
        rep_ms_q <= 10'h000;
      end else if (rep_on && tick) begin
        rep_ms_q <= rep_ms_q + 10'h001;
      end
      // Idle time restarts on every queued event (not on one dropped at a full queue) and is held at zero while keys are down
      if (push_ok || (stable_q != '0) || !awake || wr_cfg) idle_ms_q <= 11'h000;
      else if (tick && idle_ms_q != '1) idle_ms_q <= idle_ms_q + 11'h001;
      if (count_q == 5'h00 || irq_flag_q) irq_ms_q <= 6'h00;
      else if (tick && irq_ms_q != '1) irq_ms_q <= irq_ms_q + 6'h01;
      if (irq_set) irq_flag_q <= 1'b1;
      else if (irq_clr) irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      col_oe_n_q <= '0;
      irq_oe_n_q <= 1'b1;
    end else begin
      col_oe_n_q <= col_oe_n_d;
      irq_oe_n_q <= port_q[PORT_INT_GPO_BIT] ? port_q[PORT_INT_LVL_BIT] : ~irq_flag_q;
    end
  end

  assign column_drive_out = '0;
  assign column_drive_oe_n = col_oe_n_q;
  assign irq_pin_out = 1'b0;
  assign irq_pin_oe_n = irq_oe_n_q;
  assign bus_timeout_en = cfg_q[CFG_TIMEOUT_BIT];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_evq_read;
    evq_read && !ovf_q;
  endsequence
  sequence s_quiet;
    state_q == ST_IDLE && !wr_port && !wr_dbc;
  endsequence

  a_empty_read_code: assert property (
    s_evq_read ##0 (count_q == 5'h00 && !push_v) |=> core_rdata_q == CODE_EMPTY && count_q == 5'h00)
    else $error("empty queue read gave wrong code or changed count");
  a_pop_one_entry: assert property (
    s_evq_read ##0 (count_q != 5'h00 && !push_ok) |=> count_q == $past(count_q) - 5'h01)
    else $error("queue read did not remove exactly one entry");
  a_overflow_keeps: assert property (
    push_v && full && !evq_read |=> ovf_q && count_q == FULL_COUNT)
    else $error("event into full queue not dropped with overflow");
  a_special_key_flag: assert property (
    s_evq_read ##0 (count_q != 5'h00 && head.kind != KIND_REPEAT && head.key >= KEY_SPECIAL_LO)
    |=> core_rdata_q[CFG_SLEEP_BIT])
    else $error("keys 62 and 63 must read with bit seven set");
  a_held_no_sleep: assert property (
    awake && stable_q != '0 && !wr_cfg |=> awake)
    else $error("autosleep while a key is held");
  a_autowake_press: assert property (
    !awake && cfg_q[CFG_AUTOWAKE_BIT] && row_s != RST_ROWS && !wr_cfg |=> awake)
    else $error("key press in sleep did not wake");
  a_wake_disabled: assert property (
    !awake && !cfg_q[CFG_AUTOWAKE_BIT] && !wr_cfg |=> !awake)
    else $error("woke without host write while autowake is off");
  a_irq_read_clear: assert property (
    cfg_q[CFG_INTCLR_BIT] && irq_flag_q && evq_read && !irq_set |=> !irq_flag_q)
    else $error("interrupt not cleared by queue read");
  a_irq_empty_clear: assert property (
    !cfg_q[CFG_INTCLR_BIT] && count_q == 5'h00 && !irq_set |=> !irq_flag_q ##1 !irq_oe_n_q == 1'b0
    || port_q[PORT_INT_GPO_BIT])
    else $error("interrupt not cleared on empty queue");
  a_static_columns: assert property (
    s_quiet ##1 s_quiet |=> $stable(col_oe_n_q))
    else $error("columns moved while idle");
  a_scan_one_col: assert property (
    state_q == ST_SCAN && $past(state_q == ST_SCAN) |-> $countones(~col_oe_n_q & ~gpo_mask) <= 1)
    else $error("more than one key column driven during scan");
endmodule // kms_top
`default_nettype wire

/* kms_host.sv */
// Host model: register reads and writes over the link port.
// Assumes one request outstanding, each closed by a link_ack pulse.
`timescale 1ns/1ps
`default_nettype none
module kms_host (
  input wire logic link_clk,
  output logic link_req,
  output logic link_we,
  output logic [7:0] link_addr,
  output logic [7:0] link_wdata,
  input wire logic link_busy,
  input wire logic link_ack,
  input wire logic [7:0] link_rdata
);
  initial begin
    link_req = 1'b0;
    link_we = 1'b0;
    link_addr = 8'h00;
    link_wdata = 8'h00;
  end
  task automatic xfer(input logic we, input logic [7:0] a, wd, output logic [7:0] rd);
    int n;
    n = 0;
    while (link_busy !== 1'b0 && n < 16) begin
      @(posedge link_clk);
      n++;
    end
    link_req <= 1'b1;
    link_we <= we;
    link_addr <= a;
    link_wdata <= wd;
    @(posedge link_clk);
    link_req <= 1'b0;
    // Released lines must not keep showing the last value
    link_addr <= ~a;
    link_wdata <= ~wd;
    n = 0;
    while (link_ack !== 1'b1 && n < 16) begin
      @(posedge link_clk);
      n++;
    end
    // A missing answer reads as unknown so the caller's compare fails
    rd = (link_ack === 1'b1) ? link_rdata : 8'hxx;
  endtask
endmodule // kms_host
`default_nettype wire

/* tb_key_matrix_scan_fifo.sv */
// Bench for the key scanner: host on the link port, a modelled key matrix.
// Assumes pull-ups on rows; time units are shortened by parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_key_matrix_scan_fifo;
  import kms_pkg::*;
  logic core_clk, srst, link_clk, link_req, link_we, link_busy, link_ack;
  logic irq_pin_out, irq_pin_oe_n, bus_timeout_en;
  logic [7:0] link_addr, link_wdata, link_rdata, row_sense_in, column_drive_out;
  logic [7:0] column_drive_oe_n;
  logic [63:0] keys;
  int mismatches, num_checks;
  logic [7:0] rv [8] = '{8'h3F, 8'h0A, 8'hFF, 8'h00, 8'hFE, 8'h00, 8'h07, 8'h00};
  kms_top #(.MS_TICK_CYCLES(20), .SETTLE_WAIT(4)) u_dut (.core_clk(core_clk), .srst(srst),
    .link_clk(link_clk), .link_req(link_req), .link_we(link_we), .link_addr(link_addr),
    .link_wdata(link_wdata), .link_busy(link_busy), .link_ack(link_ack),
    .link_rdata(link_rdata), .row_sense_in(row_sense_in), .column_drive_out(column_drive_out),
    .column_drive_oe_n(column_drive_oe_n), .irq_pin_out(irq_pin_out),
    .irq_pin_oe_n(irq_pin_oe_n), .bus_timeout_en(bus_timeout_en));
  kms_host u_host (.link_clk(link_clk), .link_req(link_req), .link_we(link_we),
    .link_addr(link_addr), .link_wdata(link_wdata), .link_busy(link_busy),
    .link_ack(link_ack), .link_rdata(link_rdata));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  logic [7:0] row_low;
  // A closed key pulls its row low only while its column is pulled low
  always_comb begin
    row_low = 8'h00;
    for (int c = 0; c < 8; c++) begin
      row_low = row_low | (keys[c*8 +: 8] & {8{~column_drive_oe_n[c]}});
    end
  end
  always @(posedge core_clk) row_sense_in <= ~row_low;
  task automatic chk(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    logic [7:0] v;
    u_host.xfer(1'b0, a, 8'h00, v);
    chk(v, exp);
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] v;
    u_host.xfer(1'b1, a, d, v);
  endtask
  task automatic key(input int k, input logic on);
    @(posedge core_clk);
    keys[k] <= on;
    repeat (600) @(posedge core_clk);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd_chk(8'(i), rv[i]);
    wr(ADDR_EVQ, 8'h55);
    rd_chk(ADDR_EVQ, CODE_EMPTY);
    chk(column_drive_oe_n, 8'h00);
    chk(column_drive_out, 8'h00);
    chk({5'h00, irq_pin_out, irq_pin_oe_n, bus_timeout_en}, 8'h02);
    chk({7'h00, link_busy}, 8'h00);
  endtask
  task automatic t_keys;
    wr(ADDR_DBC, 8'hE0);
    key(19, 1'b1);
    rd_chk(ADDR_CFG, 8'h8A);
    rd_chk(ADDR_EVQ, 8'h13);
    repeat (3) rd_chk(ADDR_EVQ, CODE_EMPTY);
    key(19, 1'b0);
    key(19, 1'b1);
    chk({7'h00, irq_pin_oe_n}, 8'h00);
    rd_chk(ADDR_EVQ, 8'hD3);
    rd_chk(ADDR_EVQ, 8'h13);
    repeat (10) @(posedge core_clk);
    chk({7'h00, irq_pin_oe_n}, 8'h01);
    rd_chk(ADDR_EVQ, CODE_EMPTY);
    key(19, 1'b0);
    key(62, 1'b1);
    key(62, 1'b0);
    rd_chk(ADDR_EVQ, 8'hD3);
    rd_chk(ADDR_EVQ, 8'hBE);
    rd_chk(ADDR_EVQ, 8'hFE);
    rd_chk(ADDR_EVQ, CODE_EMPTY);
  endtask
  task automatic t_over;
    for (int i = 0; i < 9; i++) begin
      key(0, 1'b1);
      key(0, 1'b0);
    end
    rd_chk(ADDR_EVQ, CODE_OVERFLOW);
    for (int i = 0; i < 16; i++) rd_chk(ADDR_EVQ, {i < 15, i[0], 6'h00});
    rd_chk(ADDR_EVQ, CODE_EMPTY);
  endtask
  task automatic t_sleep;
    wr(ADDR_SLP, 8'h01);
    key(5, 1'b1);
    repeat (6000) @(posedge core_clk);
    rd_chk(ADDR_CFG, 8'h8A);
    key(5, 1'b0);
    repeat (6000) @(posedge core_clk);
    rd_chk(ADDR_CFG, 8'h0A);
    rd_chk(ADDR_EVQ, 8'h85);
    rd_chk(ADDR_EVQ, 8'h45);
  endtask
  // Read-clear and time-based interrupt, autorepeat, autowake disabled
  task automatic t_modes;
    wr(ADDR_CFG, 8'hA8);
    wr(ADDR_REP, 8'h80);
    wr(ADDR_IRQ, 8'h02);
    key(9, 1'b1);
    chk({7'h00, irq_pin_oe_n}, 8'h01);
    repeat (400) @(posedge core_clk);
    key(9, 1'b0);
    chk({7'h00, irq_pin_oe_n}, 8'h00);
    rd_chk(ADDR_EVQ, 8'h89);
    repeat (4) @(posedge core_clk);
    chk({7'h00, irq_pin_oe_n}, 8'h01);
    rd_chk(ADDR_EVQ, 8'h7E);
    rd_chk(ADDR_EVQ, 8'h49);
    wr(ADDR_REP, 8'h00);
    wr(ADDR_IRQ, 8'h20);
    wr(ADDR_CFG, 8'h28);
    key(9, 1'b1);
    rd_chk(ADDR_CFG, 8'h28);
    rd_chk(ADDR_EVQ, CODE_EMPTY);
    wr(ADDR_CFG, 8'hA8);
    // Event lands before 300 cycles, the timed interrupt well after it
    repeat (300) @(posedge core_clk);
    chk({7'h00, irq_pin_oe_n}, 8'h01);
    repeat (300) @(posedge core_clk);
    chk({7'h00, irq_pin_oe_n}, 8'h00);
    rd_chk(ADDR_EVQ, 8'h09);
    key(9, 1'b0);
    rd_chk(ADDR_EVQ, 8'h49);
    rd_chk(ADDR_EVQ, CODE_EMPTY);
  endtask
  task automatic t_gpo;
    wr(ADDR_DBC, 8'h00);
    wr(ADDR_PORT, 8'hA9);
    repeat (10) @(posedge core_clk);
    chk(column_drive_oe_n, 8'hA8);
    chk({7'h00, irq_pin_oe_n}, 8'h00);
    wr(ADDR_PORT, 8'h57);
    repeat (10) @(posedge core_clk);
    chk(column_drive_oe_n, 8'h54);
    chk({7'h00, irq_pin_oe_n}, 8'h01);
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    keys = '0;
    srst = 1'b1;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    repeat (6) @(posedge link_clk);
    t_reset;
    t_keys;
    t_over;
    t_sleep;
    t_modes;
    t_gpo;
    finish_test;
  end
  initial begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    finish_test;
  end
endmodule // tb_key_matrix_scan_fifo
`default_nettype wire
